// ---- common/fout_consts.vh ----
// Contract
// - Scaled frequency: below 1.2 Hz none, clamp 1000 Hz
// - Scaled frequency follows linearised calculated flow
// - Passthrough mode copies measured input frequency
// - One pulse per configured total increment
// - Pulse width settable 1 to 420 ms
// - Polarity sets idle and pulse levels
// - Flow limit switches with hysteresis thresholds
// - Flow limit output level follows polarity
// - Temperature limit switches with hysteresis thresholds
// - Temperature limit output level follows polarity
// - Batch limit output high above batch value (code: level follows polarity, low above it when polarity low)
// - Off mode holds output disabled
// - Analog: zero flow 4 mA, end flow 20 mA
// - Inactive analog mode holds 4 mA
// - Single input batch reset clears batch
// - Single input hold suspends total and batch
// - Two inputs: A resets, B holds, fixed
// - External bank select overrides reset and hold
// - Both low bank1, A bank2, B bank3
// - Linearisation fixed bank, off, or external
// - Enabled pushbutton clears batch, else ignored
// - Save copies settings, not linearisation table
// - Recall restores saved settings
//
// Purpose: constants for the flow output and control block
// Assumes: 50 MHz clock; frequencies in units of 0.1 Hz
// Notes: analog output code is in microamps
`ifndef FOUT_CONSTS_VH
`define FOUT_CONSTS_VH

// ----------------------------------------
// Digital output modes
// ----------------------------------------
`define FOUT_DM_OFF 3'h0
`define FOUT_DM_PASS 3'h1
`define FOUT_DM_SCALED 3'h2
`define FOUT_DM_TOTAL 3'h3
`define FOUT_DM_FLIM 3'h4
`define FOUT_DM_TLIM 3'h5
`define FOUT_DM_BLIM 3'h6

// ----------------------------------------
// Linearisation settings
// ----------------------------------------
`define FOUT_LIN_OFF 3'h0
`define FOUT_LIN_B1 3'h1
`define FOUT_LIN_B2 3'h2
`define FOUT_LIN_B3 3'h3
`define FOUT_LIN_EXT 3'h4

// ----------------------------------------
// Timing and limits
// ----------------------------------------
`define FOUT_CLK_HZ 50000000
`define FOUT_MS_CYC (`FOUT_CLK_HZ / 1000)
`define FOUT_FMIN_DHZ 32'h0000000C
`define FOUT_FMAX_DHZ 32'h00002710
`define FOUT_DHZ_CLK (`FOUT_CLK_HZ * 10)
`define FOUT_PW_MIN 9'h001
`define FOUT_PW_MAX 9'h1A4
`define FOUT_I_ZERO_UA 16'h0FA0
`define FOUT_I_SPAN_UA 16'h3E80

`endif

// ---- core/fout_ctrl.v ----
// Purpose: digital output, analog code, control inputs, settings backup
// Assumes: inputs synchronous to mclk_i; settings held by this block
// Notes: frequencies in 0.1 Hz units, pulse widths in ms
`timescale 1ns/1ps
`include "fout_consts.vh"

module fout_ctrl (
    // Clock and reset
    input wire mclk_i,
    input wire srst_i,
    // Live settings from menu
    input wire set_load_i,
    input wire [2:0] dig_mode_i,
    input wire pol_high_i,
    input wire [8:0] pulse_width_setting_i,
    input wire [31:0] incr_i,
    input wire [31:0] frequency_full_range_flow_i,
    input wire [31:0] limit_i,
    input wire [7:0] hyst_pct_i,
    input wire analog_flow_i,
    input wire [31:0] analog_end_flow_i,
    input wire batch_clear_function_i,
    input wire two_inputs_i,
    input wire [2:0] lin_mode_i,
    input wire key_enable_i,
    // Save and recall strobes
    input wire save_i,
    input wire recall_i,
    // Measurements
    input wire [31:0] flow_i,
    input wire [31:0] flow_lin_i,
    input wire [31:0] temp_i,
    input wire [31:0] in_freq_i,
    input wire meas_pulse_i,
    input wire [31:0] flow_inc_i,
    // Control inputs and pushbutton
    input wire ctl_a_i,
    input wire ctl_b_i,
    input wire key_press_i,
    // Outputs
    output reg dig_out_o,
    output reg [15:0] analog_ua_o,
    output reg [1:0] lin_bank_o,
    output reg [47:0] total_o,
    output reg [47:0] batch_o,
    output wire hold_o
);

    // ----------------------------------------
    // Active and backup settings
    // ----------------------------------------
    reg [2:0] dmode;
    reg pol;
    reg [8:0] pw;
    reg [31:0] incr;
    reg [31:0] fsflow;
    reg [31:0] lim;
    reg [7:0] hyst;
    reg amode;
    reg [31:0] aend;
    reg bclr;
    reg [2:0] lmode;
    reg keyen;
    reg [151:0] backup;
    wire [151:0] active_vec;
    assign active_vec = {dmode, pol, pw, incr, fsflow, lim, hyst, amode, aend, bclr, keyen};

    // Clamp width to the settable range
    function [8:0] fout_clamp_pw;
        input [8:0] v;
        begin
            if (v < `FOUT_PW_MIN)
                fout_clamp_pw = `FOUT_PW_MIN;
            else if (v > `FOUT_PW_MAX)
                fout_clamp_pw = `FOUT_PW_MAX;
            else
                fout_clamp_pw = v;
        end
    endfunction

    // Settings load, save and recall; linearisation mode is never backed up
    always @(posedge mclk_i) begin
        if (srst_i) begin
            dmode <= `FOUT_DM_OFF;
            pol <= 1'b1;
            pw <= `FOUT_PW_MIN;
            incr <= 32'h00000001;
            fsflow <= 32'h00000001;
            lim <= 32'h00000000;
            hyst <= 8'h00;
            amode <= 1'b0;
            aend <= 32'h00000001;
            bclr <= 1'b1;
            lmode <= `FOUT_LIN_OFF;
            keyen <= 1'b0;
            backup <= 152'h0;
        end else begin
            if (set_load_i) begin
                dmode <= dig_mode_i;
                pol <= pol_high_i;
                pw <= fout_clamp_pw(pulse_width_setting_i);
                incr <= incr_i;
                fsflow <= frequency_full_range_flow_i;
                lim <= limit_i;
                hyst <= hyst_pct_i;
                amode <= analog_flow_i;
                aend <= analog_end_flow_i;
                bclr <= batch_clear_function_i;
                lmode <= lin_mode_i;
                keyen <= key_enable_i;
            end else if (recall_i) begin
                {dmode, pol, pw, incr, fsflow, lim, hyst, amode, aend, bclr, keyen}
                    <= backup;
            end
            if (save_i)
                backup <= active_vec;
        end
    end

    // ----------------------------------------
    // Control inputs and bank selection
    // ----------------------------------------
    reg [1:0] ext_bank;
    wire ext_sel;
    wire clr_in;
    wire hold_in;
    assign ext_sel = (lmode == `FOUT_LIN_EXT) && two_inputs_i;
    assign clr_in = ext_sel ? 1'b0 : (two_inputs_i ? ctl_a_i : (bclr & ctl_a_i));
    assign hold_in = ext_sel ? 1'b0 : (two_inputs_i ? ctl_b_i : (~bclr & ctl_a_i));
    assign hold_o = hold_in;

    // External bank: both inputs high keeps the previous bank
    always @(posedge mclk_i) begin
        if (srst_i)
            ext_bank <= 2'h1;
        else if (!ctl_a_i && !ctl_b_i)
            ext_bank <= 2'h1;
        else if (ctl_a_i && !ctl_b_i)
            ext_bank <= 2'h2;
        else if (ctl_b_i && !ctl_a_i)
            ext_bank <= 2'h3;
    end

    // Active bank, zero means linearisation off
    always @(posedge mclk_i) begin
        if (srst_i)
            lin_bank_o <= 2'h0;
        else if (ext_sel)
            lin_bank_o <= ext_bank;
        else if (lmode == `FOUT_LIN_B1 || lmode == `FOUT_LIN_B2 || lmode == `FOUT_LIN_B3)
            lin_bank_o <= lmode[1:0];
        else
            lin_bank_o <= 2'h0;
    end

    // ----------------------------------------
    // Totals, batch and pulse credit
    // ----------------------------------------
    reg [31:0] acc;
    reg [15:0] credit;
    wire step;
    assign step = (acc + flow_inc_i) >= incr;

    // Accumulate unless held; batch clear by input or enabled key
    always @(posedge mclk_i) begin
        if (srst_i) begin
            total_o <= 48'h0;
            batch_o <= 48'h0;
            acc <= 32'h0;
        end else begin
            if (!hold_in) begin
                total_o <= total_o + {16'h0, flow_inc_i};
                acc <= step ? (acc + flow_inc_i - incr) : (acc + flow_inc_i);
            end
            if (clr_in || (key_press_i && keyen))
                batch_o <= 48'h0;
            else if (!hold_in)
                batch_o <= batch_o + {16'h0, flow_inc_i};
        end
    end

    // ----------------------------------------
    // Totaliser pulse generator
    // ----------------------------------------
    reg [25:0] pcnt;
    reg pulse_on;
    wire start_p;
    wire [31:0] pw_cyc;
    assign start_p = !pulse_on && (credit != 16'h0);
    // Pulse length in cycles; 420 ms still fits the 26-bit counter
    assign pw_cyc = pw * `FOUT_MS_CYC - 1;

    // Queue of owed pulses, each lasting pw milliseconds
    always @(posedge mclk_i) begin
        if (srst_i || dmode != `FOUT_DM_TOTAL) begin
            credit <= 16'h0;
            pulse_on <= 1'b0;
            pcnt <= 26'h0;
        end else begin
            credit <= credit + {15'h0, step & !hold_in} - {15'h0, start_p};
            if (start_p) begin
                pulse_on <= 1'b1;
                pcnt <= pw_cyc[25:0];
            end else if (pulse_on) begin
                if (pcnt == 26'h0)
                    pulse_on <= 1'b0;
                else
                    pcnt <= pcnt - 26'h1;
            end
        end
    end

    // ----------------------------------------
    // Scaled frequency generator
    // ----------------------------------------
    reg [63:0] fprod;
    reg [31:0] ftgt;
    reg [31:0] phase;
    reg fsq;
    wire [31:0] fsrc;
    assign fsrc = (lin_bank_o != 2'h0) ? flow_lin_i : flow_i;

    // Target in 0.1 Hz, blanked low and clamped high
    always @* begin
        fprod = ({32'h0, fsrc} * 64'd10000) / {32'h0, fsflow};
        if (fprod < {32'h0, `FOUT_FMIN_DHZ})
            ftgt = 32'h0;
        else if (fprod > {32'h0, `FOUT_FMAX_DHZ})
            ftgt = `FOUT_FMAX_DHZ;
        else
            ftgt = fprod[31:0];
    end

    // Phase accumulator toggles twice per period
    always @(posedge mclk_i) begin
        if (srst_i || ftgt == 32'h0) begin
            phase <= 32'h0;
            fsq <= 1'b0;
        end else if (phase + 2 * ftgt >= `FOUT_DHZ_CLK) begin
            phase <= phase + 2 * ftgt - `FOUT_DHZ_CLK;
            fsq <= ~fsq;
        end else begin
            phase <= phase + 2 * ftgt;
        end
    end

    // ----------------------------------------
    // Limit switches with hysteresis
    // ----------------------------------------
    reg flim_st;
    reg tlim_st;
    wire [31:0] hband;
    assign hband = (lim * hyst) / 32'd100;

    // Latch states set above upper, cleared below lower threshold
    always @(posedge mclk_i) begin
        if (srst_i) begin
            flim_st <= 1'b0;
            tlim_st <= 1'b0;
        end else begin
            if (flow_i > lim + hband)
                flim_st <= 1'b1;
            else if (flow_i < lim - hband)
                flim_st <= 1'b0;
            if (temp_i > lim + hband)
                tlim_st <= 1'b1;
            else if (temp_i < lim - hband)
                tlim_st <= 1'b0;
        end
    end

    // ----------------------------------------
    // Output selection and polarity
    // ----------------------------------------
    reg act;
    always @* begin
        case (dmode)
            `FOUT_DM_PASS: act = meas_pulse_i;
            `FOUT_DM_SCALED: act = fsq;
            `FOUT_DM_TOTAL: act = pulse_on;
            `FOUT_DM_FLIM: act = flim_st;
            `FOUT_DM_TLIM: act = tlim_st;
            `FOUT_DM_BLIM: act = batch_o > {16'h0, lim};
            default: act = 1'b0;
        endcase
    end

    // Registered output; off mode forces the output low whatever the polarity
    always @(posedge mclk_i) begin
        if (srst_i)
            dig_out_o <= 1'b0;
        else if (dmode == `FOUT_DM_OFF || dmode == 3'h7)
            dig_out_o <= 1'b0;
        else if (dmode == `FOUT_DM_PASS)
            dig_out_o <= act;
        else
            dig_out_o <= pol ? act : ~act;
    end

    // ----------------------------------------
    // Analog current code
    // ----------------------------------------
    reg [63:0] aprod;
    always @* begin
        aprod = ({32'h0, flow_i} * {48'h0, `FOUT_I_SPAN_UA}) / {32'h0, aend};
        if (aprod > {48'h0, `FOUT_I_SPAN_UA})
            aprod = {48'h0, `FOUT_I_SPAN_UA};
    end

    always @(posedge mclk_i) begin
        if (srst_i || !amode)
            analog_ua_o <= `FOUT_I_ZERO_UA;
        else
            analog_ua_o <= `FOUT_I_ZERO_UA + aprod[15:0];
    end

endmodule // fout_ctrl

// ---- test/fout_chk.sv ----
// Purpose: port checks for fout_ctrl
// Assumes: active settings shadowed at set_load_i
// Notes: checks pause after a recall until the next load
`timescale 1ns/1ps
module fout_chk (
    // Clock, reset, settings and live inputs
    input wire mclk_i,
    input wire srst_i,
    input wire set_load_i,
    input wire recall_i,
    input wire [2:0] dig_mode_i,
    input wire pol_high_i,
    input wire analog_flow_i,
    input wire two_inputs_i,
    input wire [2:0] lin_mode_i,
    input wire key_enable_i,
    input wire [31:0] limit_i,
    input wire [7:0] hyst_pct_i,
    input wire [31:0] flow_i,
    input wire ctl_a_i,
    input wire ctl_b_i,
    input wire key_press_i,
    // Outputs watched
    input wire dig_out_o,
    input wire [15:0] analog_ua_o,
    input wire [1:0] lin_bank_o,
    input wire [47:0] total_o,
    input wire [47:0] batch_o,
    input wire hold_o
);
reg ok, pl, af, tw, ke;
reg [2:0] md, ln;
reg [31:0] lm;
reg [7:0] hp;
wire q = ok && !set_load_i && !recall_i;
wire [47:0] f100 = flow_i * 48'h64;
wire [47:0] up = lm * (48'h64 + hp);
wire [47:0] dn = lm * (48'h64 - hp);
// Shadow of the active settings
always @(posedge mclk_i) begin
    ok <= srst_i ? 1'b0 : set_load_i | (ok & ~recall_i);
    if (set_load_i) begin
        {md, pl, af, tw, ln, ke} <= {dig_mode_i, pol_high_i, analog_flow_i, two_inputs_i,
            lin_mode_i, key_enable_i};
        {lm, hp} <= {limit_i, hyst_pct_i};
    end
end
default clocking @(posedge mclk_i); endclocking
default disable iff (srst_i);
a_off_mode_low: assert property (q && md == 3'h0 && pl |=> !dig_out_o)
    else $error("output active in off mode");
a_fixed_analog: assert property (q && !af |=> analog_ua_o == 16'h0FA0)
    else $error("analog not at 4 mA");
a_flow_rise: assert property (q && md == 3'h4 && f100 > up |-> ##2 dig_out_o == pl)
    else $error("flow limit not active");
a_flow_fall: assert property (q && md == 3'h4 && f100 < dn |-> ##2 dig_out_o != pl)
    else $error("flow limit not released");
a_fixed_bank: assert property (q && ln < 3'h4 |=> lin_bank_o == ln[1:0])
    else $error("fixed bank wrong");
a_ext_bank: assert property (q && ln == 3'h4 && tw && !(ctl_a_i && ctl_b_i) ##1 two_inputs_i |=>
    lin_bank_o == ($past(ctl_a_i, 2) ? 2'h2 : $past(ctl_b_i, 2) ? 2'h3 : 2'h1))
    else $error("external bank wrong");
a_key_clear: assert property (q && ke && key_press_i |=> batch_o == 48'h0)
    else $error("key did not clear batch");
a_hold_freeze: assert property (hold_o |=> $stable(total_o))
    else $error("total moved during hold");
c_pulse: cover property (q && md == 3'h3 && $rose(dig_out_o));
c_ext: cover property (q && ln == 3'h4 && ctl_b_i);
c_hold: cover property (hold_o [*3]);
endmodule // fout_chk
bind fout_ctrl fout_chk u_chk (.*);

// ---- test/fout_ctrl_tb.sv ----
// Purpose: self-checking bench for fout_ctrl
// Assumes: 50 MHz clock, inputs driven 1 ns after the edge
// Notes: pulse width and scaled period dominate run time
`timescale 1ns/1ps
module fout_ctrl_tb;
reg mclk_i, srst_i, set_load_i, pol_high_i, analog_flow_i, batch_clear_function_i;
reg two_inputs_i, key_enable_i, save_i, recall_i, meas_pulse_i, key_press_i;
reg [2:0] dig_mode_i, lin_mode_i;
reg [8:0] pulse_width_setting_i;
reg [7:0] hyst_pct_i;
reg [31:0] incr_i, frequency_full_range_flow_i, limit_i, analog_end_flow_i, flow_i;
reg [31:0] flow_lin_i, temp_i, in_freq_i, flow_inc_i;
reg [1:0] sel;
reg [47:0] t;
wire ctl_a_i, ctl_b_i, dig_out_o, hold_o;
wire [15:0] analog_ua_o, n_pulse;
wire [1:0] lin_bank_o;
wire [47:0] total_o, batch_o;
integer n_errors = 0, n_compared = 0, i, k;
fout_ctrl uut (.*);
fout_far far (.mclk_i(mclk_i), .sel_i(sel), .pol_high_i(pol_high_i),
    .dig_out_i(dig_out_o), .ctl_a_o(ctl_a_i), .ctl_b_o(ctl_b_i), .n_pulse_o(n_pulse));
// Clock
initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
end
task cyc(input integer n);
    begin
        repeat (n) @(posedge mclk_i);
        #1;
    end
endtask
task chk(input [47:0] got, input [47:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %0h not %0h", $time, got, exp);
        end
    end
endtask
task close_out;
    begin
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end
endtask
// Wait for a level, leaving the wait length in i
task wt(input v);
    begin
        for (i = 0; dig_out_o !== v; i = i + 1) begin
            if (i > 60000) begin
                n_errors = n_errors + 1;
                close_out;
            end
            cyc(1);
        end
    end
endtask
task ld(input [2:0] m, input p);
    begin
        {dig_mode_i, pol_high_i, set_load_i} = {m, p, 1'b1};
        cyc(1);
        set_load_i = 1'b0;
        cyc(1);
    end
endtask
task inc(input integer n);
    begin
        flow_inc_i = 32'h1;
        cyc(n);
        flow_inc_i = 32'h0;
    end
endtask
task lim(input [2:0] m, input p, input [39:0] v, input [4:0] e);
    begin
        ld(m, p);
        for (k = 0; k < 5; k = k + 1) begin
            flow_i = (m == 3'h4) ? 32'(v[39 - 8 * k -: 8]) : 32'h0;
            temp_i = (m == 3'h5) ? 32'(v[39 - 8 * k -: 8]) : 32'h0;
            cyc(3);
            chk(48'(dig_out_o), 48'(e[4 - k]));
        end
    end
endtask
// Main sequence
initial begin
    {set_load_i, analog_flow_i, batch_clear_function_i, two_inputs_i, key_enable_i} = 5'h0;
    {save_i, recall_i, meas_pulse_i, key_press_i, pol_high_i, srst_i} = 6'h3;
    {incr_i, limit_i, analog_end_flow_i, flow_i, flow_lin_i, temp_i} = 192'h0;
    {in_freq_i, flow_inc_i, frequency_full_range_flow_i} = 96'h3E8;
    {dig_mode_i, lin_mode_i, pulse_width_setting_i, hyst_pct_i, sel} = 25'h0;
    cyc(2);
    srst_i = 1'b0;
    cyc(1);
    chk(48'(analog_ua_o), 48'hFA0);
    incr_i = 32'hA;
    ld(3'h3, 1'b1);
    flow_inc_i = 32'h5;
    cyc(1);
    flow_inc_i = 32'h0;
    cyc(4);
    chk(48'(dig_out_o), 48'h0);
    k = 32'(n_pulse);
    flow_inc_i = 32'h5;
    cyc(1);
    flow_inc_i = 32'h0;
    wt(1'b1);
    wt(1'b0);
    chk(48'(i), 48'hC350);
    chk(48'(n_pulse) - 48'(k), 48'h1);
    {flow_i, flow_lin_i, lin_mode_i} = {32'h1, 32'h1388, 3'h1};
    ld(3'h2, 1'b1);
    wt(1'b1);
    wt(1'b0);
    chk(48'(i), 48'h61A8);
    {limit_i, hyst_pct_i} = {32'h64, 8'h5};
    lim(3'h4, 1'b0, 40'h686A605E68, 5'b10011);
    limit_i = 32'h5A;
    lim(3'h5, 1'b1, 40'h5E5F56555F, 5'b01101);
    {limit_i, batch_clear_function_i, sel} = {32'h14, 1'b1, 2'h1};
    ld(3'h6, 1'b1);
    sel = 2'h0;
    cyc(2);
    chk(batch_o, 48'h0);
    inc(20);
    cyc(2);
    chk(48'(dig_out_o), 48'h0);
    inc(1);
    cyc(2);
    chk(48'(dig_out_o), 48'h1);
    key_press_i = 1'b1;
    cyc(2);
    chk(batch_o, 48'h15);
    key_enable_i = 1'b1;
    ld(3'h6, 1'b1);
    key_press_i = 1'b0;
    cyc(2);
    chk(batch_o, 48'h0);
    {batch_clear_function_i, sel} = {1'b0, 2'h1};
    ld(3'h6, 1'b1);
    t = total_o;
    inc(4);
    chk(total_o, t);
    chk(batch_o, 48'h0);
    {two_inputs_i, sel} = {1'b1, 2'h0};
    ld(3'h6, 1'b1);
    inc(4);
    sel = 2'h2;
    cyc(2);
    t = total_o;
    inc(4);
    chk(total_o, t);
    chk(batch_o, 48'h4);
    sel = 2'h1;
    cyc(4);
    chk(batch_o, 48'h0);
    for (k = 0; k < 5; k = k + 1) begin
        {lin_mode_i, sel} = {k[2:0], 2'h0};
        ld(3'h0, 1'b1);
        inc(1);
        cyc(3);
        chk(48'(lin_bank_o), (k == 4) ? 48'h1 : 48'(k));
    end
    for (k = 1; k < 3; k = k + 1) begin
        sel = k[1:0];
        cyc(4);
        chk(48'(lin_bank_o), 48'(k + 1));
    end
    chk(batch_o, 48'h5);
    {analog_end_flow_i, analog_flow_i, lin_mode_i, flow_i} = {32'h3E8, 1'b1, 3'h2, 32'h0};
    ld(3'h0, 1'b1);
    chk(48'(analog_ua_o), 48'hFA0);
    flow_i = 32'h3E8;
    cyc(3);
    chk(48'(analog_ua_o), 48'h4E20);
    {flow_i, save_i} = {32'h1F4, 1'b1};
    cyc(1);
    {save_i, analog_flow_i, lin_mode_i} = {1'b0, 1'b0, 3'h1};
    ld(3'h0, 1'b1);
    cyc(1);
    chk(48'(analog_ua_o), 48'hFA0);
    recall_i = 1'b1;
    cyc(1);
    recall_i = 1'b0;
    cyc(3);
    chk(48'(analog_ua_o), 48'h2EE0);
    chk(48'(lin_bank_o), 48'h1);
    // Passthrough copies the raw pulse, whatever the polarity
    ld(3'h1, 1'b0);
    meas_pulse_i = 1'b1;
    cyc(2);
    chk(48'(dig_out_o), 48'h1);
    meas_pulse_i = 1'b0;
    cyc(2);
    chk(48'(dig_out_o), 48'h0);
    close_out;
end
endmodule // fout_ctrl_tb

// ---- test/fout_far.sv ----
// Purpose: far side, control-input driver and pulse counter
// Assumes: sel_i set by the bench just after a clock edge
// Notes: both control inputs are never high together
`timescale 1ns/1ps
module fout_far (
    // From the bench and the block
    input wire mclk_i,
    input wire [1:0] sel_i,
    input wire pol_high_i,
    input wire dig_out_i,
    // To the block and the bench
    output reg ctl_a_o = 1'b0,
    output reg ctl_b_o = 1'b0,
    output reg [15:0] n_pulse_o = 16'h0
);
reg act = 1'b0;
// Release the old input before raising the new one
always @(posedge mclk_i) begin
    ctl_a_o <= sel_i == 2'h1 && !ctl_b_o;
    ctl_b_o <= sel_i == 2'h2 && !ctl_a_o;
end
// Count edges into the active level
always @(posedge mclk_i) begin
    act <= dig_out_i == pol_high_i;
    if (dig_out_i == pol_high_i && !act) n_pulse_o <= n_pulse_o + 16'h1;
end
endmodule // fout_far
